//--- src/smr_pkg.sv
// Package: register map, field positions and shared types for the management routing bank.
package smr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_SMI_ENABLE_TWO   = 8'h19;
    localparam logic [7:0] OFF_SMI_ENABLE_THREE = 8'h1A;
    localparam logic [7:0] OFF_SMI_ENABLE_FOUR  = 8'h1B;
    localparam logic [7:0] OFF_EDGE_PIN_STATUS  = 8'h1C;
    localparam logic [7:0] OFF_POWER_GOOD_SEL   = 8'h1D;
    localparam logic [7:0] OFF_FORCED_MEDIA     = 8'h1E;
    localparam logic [7:0] OFF_IRQ_STATUS       = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK         = 8'h31;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [7:0] RST_FORCED_MEDIA  = 8'h03;
    localparam logic [7:0] EN2_VALID_MASK    = 8'hF7;
    localparam logic [7:0] EN3_VALID_MASK    = 8'hFE;
    localparam logic [7:0] EN4_UART_MASK     = 8'h53;
    localparam logic [7:0] EDGE_VALID_MASK   = 8'h33;
    localparam logic [7:0] PGS_VALID_MASK    = 8'h07;
    localparam logic [7:0] FORCE_VALID_MASK  = 8'h03;
    localparam logic [2:0] IRQ_VALID_MASK    = 3'h7;
    localparam int BIT_TO_WAKE   = 5;
    localparam int BIT_TO_SERIAL = 6;
    localparam int BIT_TO_PIN    = 7;
    localparam int BIT_WDT2_SRC  = 0;
    localparam int BIT_THERM_SRC = 1;
    localparam int BIT_WDT2_IN   = 2;

    // Event bits of the block interrupt status register.
    localparam int EVT_EDGE  = 0;
    localparam int EVT_GROUP = 1;
    localparam int EVT_FORCE = 2;

    // Source bundles carried into the bank.
    typedef struct packed {
        logic mouseIrq;
        logic keyboardIrq;
        logic infraredIrq;
        logic mouseClickEvent;
        logic [7:0] gpioGroupThree;  // Bit 0 unused; 21,22,54,55,56,57,60.
        logic [7:0] groupFour;       // U3,U4,32,33,U5,42,U6,61.
    } smr_sources_t;

    typedef struct packed {
        logic headStepPulse;
        logic driveSelectZero;
        logic driveSelectOne;
        logic mediaChangedPin;
    } smr_floppy_t;

endpackage

//--- src/smr_routing_regs.sv
// Management interrupt routing, edge status, power-good selects and forced media change.
// How it works
// [RULE_01] Enable bit 1 passes source, 0 blocks.
// [RULE_02] Enable two: mouse, keyboard, infrared, click.
// [RULE_03] Bit 5 routes group into wake logic.
// [RULE_04] Bit 6 routes group onto serial IRQ.
// [RULE_05] Bit 7 routes group onto pin.
// [RULE_06] Enable three gates seven GPIO sources.
// [RULE_07] Enable four gates UARTs and GPIO pins.
// [RULE_08] Edge status bits clear on written one.
// [RULE_09] Edge status sets on either pin edge.
// [RULE_10] Edge status bits 7:6 read zero.
// [RULE_11] Bit 0 selects watchdog as power-good source.
// [RULE_12] Bit 1 selects thermal trip as source.
// [RULE_13] Bit 2 is watchdog software input.
// [RULE_14] Force bits per drive, reset 0x03.
// [RULE_15] Software may set, never clear, force bits.
// [RULE_16] Step or drive select clears force bit.
// [RULE_17] Media flag combines selects, force, pin.
// [RULE_18] Missing UARTs make enable-four bits reserved.
module smr_routing_regs
    import smr_pkg::*;
#(
    parameter bit HAS_EXTRA_UARTS = 1'b1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Avalon-MM slave
    input  wire logic [9:0]   address,
    input  wire logic         read,
    input  wire logic         write,
    input  wire logic [31:0]  writedata,
    input  wire logic [3:0]   byteenable,
    output logic [31:0]       readdata,
    output logic              waitrequest,
    output logic [1:0]        response,
    // Event sources
    input  wire smr_sources_t sources,
    input  wire logic         gpioPin21,
    input  wire logic         gpioPin22,
    input  wire logic         gpioPin60,
    input  wire logic         gpioPin61,
    input  wire logic         secondWatchdogEvent,
    input  wire logic         thermalTrip,
    input  wire smr_floppy_t  floppy,
    // Routed outputs
    output logic              groupMgmtInterrupt,
    output logic              mgmtInterruptPinN,
    output logic              groupToSerialIrq,
    output logic              groupToWakeLogic,
    output logic              powerGoodResetRequest,
    output logic              secondWatchdogInputBit,
    output logic              mediaChangedFlag,
    output logic              irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] smiEnableTwo;
    logic [7:0] smiEnableThree;
    logic [7:0] smiEnableFour;
    logic [7:0] edgePinStatus;
    logic [7:0] powerGoodSourceSelect;
    logic [7:0] forcedMediaChange;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [3:0] pinLast;
    logic       groupLast;
    logic       forceLast;
    logic       reqDone;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Every access answers one cycle after it is presented: the first
    // cycle of a request waits, the second completes it.
    wire [7:0] regIndex   = address[9:2];
    wire       wordAlign  = (address[1:0] == 2'b00);
    wire       accessReq  = (read | write) & ~reqDone;
    wire       hitEn2     = wordAlign && (regIndex == OFF_SMI_ENABLE_TWO);
    wire       hitEn3     = wordAlign && (regIndex == OFF_SMI_ENABLE_THREE);
    wire       hitEn4     = wordAlign && (regIndex == OFF_SMI_ENABLE_FOUR);
    wire       hitEdge    = wordAlign && (regIndex == OFF_EDGE_PIN_STATUS);
    wire       hitPgs     = wordAlign && (regIndex == OFF_POWER_GOOD_SEL);
    wire       hitForce   = wordAlign && (regIndex == OFF_FORCED_MEDIA);
    wire       hitIrqSts  = wordAlign && (regIndex == OFF_IRQ_STATUS);
    wire       hitIrqMask = wordAlign && (regIndex == OFF_IRQ_MASK);
    wire       hitAny     = hitEn2 | hitEn3 | hitEn4 | hitEdge | hitPgs | hitForce
                            | hitIrqSts | hitIrqMask;
    wire       wrTake     = write & reqDone & byteenable[0];
    wire [7:0] wrByte     = writedata[7:0];

    // Enable-four bits that exist on this build.
    // [RULE_18] reserved UART positions
    wire [7:0] en4Mask = HAS_EXTRA_UARTS ? 8'hFF : ~EN4_UART_MASK;

    assign waitrequest = accessReq;

    // ------------------------------------------------------------------
    // Group interrupt routing
    // ------------------------------------------------------------------
    // [RULE_02] enable two sources
    // [RULE_01] per-bit source gating
    wire       hitTwo   = |(smiEnableTwo[4:0] & {sources.mouseClickEvent, 1'b0,
                           sources.infraredIrq, sources.keyboardIrq, sources.mouseIrq});
    // [RULE_06] gpio group three gating
    wire       hitThree = |(smiEnableThree & sources.gpioGroupThree & EN3_VALID_MASK);
    // [RULE_07] group four gating
    wire       hitFour  = |(smiEnableFour & sources.groupFour & en4Mask);

    assign groupMgmtInterrupt = hitTwo | hitThree | hitFour;
    // [RULE_03] route into wake logic
    assign groupToWakeLogic   = groupMgmtInterrupt & smiEnableTwo[BIT_TO_WAKE];
    // [RULE_04] route onto serial stream
    assign groupToSerialIrq   = groupMgmtInterrupt & smiEnableTwo[BIT_TO_SERIAL];
    // [RULE_05] route onto pin, active low
    assign mgmtInterruptPinN  = ~(groupMgmtInterrupt & smiEnableTwo[BIT_TO_PIN]);

    // ------------------------------------------------------------------
    // Power-good sources and floppy flag
    // ------------------------------------------------------------------
    // [RULE_11] watchdog source select
    wire pgWdt   = powerGoodSourceSelect[BIT_WDT2_SRC] & secondWatchdogEvent;
    // [RULE_12] thermal source select
    wire pgTherm = powerGoodSourceSelect[BIT_THERM_SRC] & thermalTrip;
    assign powerGoodResetRequest  = pgWdt | pgTherm;
    // [RULE_13] watchdog software bit
    assign secondWatchdogInputBit = powerGoodSourceSelect[BIT_WDT2_IN];
    // [RULE_17] media change flag
    assign mediaChangedFlag = (floppy.driveSelectZero & forcedMediaChange[0])
                            | (floppy.driveSelectOne & forcedMediaChange[1])
                            | floppy.mediaChangedPin;

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    wire [3:0] pinNow   = {gpioPin61, gpioPin60, gpioPin22, gpioPin21};
    wire [3:0] pinEdge  = pinNow ^ pinLast;
    // [RULE_09] either-edge status set
    wire [7:0] edgeSet  = {2'b00, pinEdge[3], pinEdge[2], 2'b00, pinEdge[1], pinEdge[0]};
    // [RULE_08] write-one clear
    wire [7:0] edgeClr  = (wrTake && hitEdge) ? wrByte : RST_ZERO;
    // Set wins over clear so no edge is lost in the clearing cycle.
    // [RULE_10] reserved bits stay zero
    wire [7:0] next_edgePinStatus = ((edgePinStatus & ~edgeClr) | edgeSet) & EDGE_VALID_MASK;

    // Force bits: software sets, drive activity clears, set wins.
    // [RULE_16] step and select clear
    wire [1:0] forceClr = {floppy.headStepPulse | floppy.driveSelectOne,
                           floppy.headStepPulse | floppy.driveSelectZero};
    // [RULE_15] software only sets
    wire [1:0] forceSet = (wrTake && hitForce) ? wrByte[1:0] : 2'b00;
    wire [7:0] next_forcedMediaChange = {6'h00, (forcedMediaChange[1:0] & ~forceClr) | forceSet};

    // Block interrupt events.
    wire       groupRise = groupMgmtInterrupt & ~groupLast;
    wire       forceFall = (|forcedMediaChange[1:0]) == 1'b0 && forceLast;
    wire [2:0] evtSet    = {forceFall, groupRise, |edgeSet};
    wire [2:0] evtClr    = (wrTake && hitIrqSts) ? wrByte[2:0] : 3'h0;
    wire [2:0] next_irqStatus = ((irqStatus & ~evtClr) | evtSet) & IRQ_VALID_MASK;

    assign irq = |(irqStatus & irqMask);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            smiEnableTwo          <= RST_ZERO;
            smiEnableThree        <= RST_ZERO;
            smiEnableFour         <= RST_ZERO;
            powerGoodSourceSelect <= RST_ZERO;
            irqMask               <= 3'h0;
        end else if (wrTake) begin
            if (hitEn2) begin
                smiEnableTwo <= wrByte & EN2_VALID_MASK;
            end else if (hitEn3) begin
                smiEnableThree <= wrByte & EN3_VALID_MASK;
            end else if (hitEn4) begin
                smiEnableFour <= wrByte & en4Mask;
            end else if (hitPgs) begin
                powerGoodSourceSelect <= wrByte & PGS_VALID_MASK;
            end else if (hitIrqMask) begin
                irqMask <= wrByte[2:0];
            end
        end
    end

    // Status, history and handshake state.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            edgePinStatus     <= RST_ZERO;
            // [RULE_14] force bits reset active
            forcedMediaChange <= RST_FORCED_MEDIA;
            irqStatus         <= 3'h0;
            pinLast           <= 4'h0;
            groupLast         <= 1'b0;
            forceLast         <= 1'b1;
            reqDone           <= 1'b0;
        end else begin
            edgePinStatus     <= next_edgePinStatus;
            forcedMediaChange <= next_forcedMediaChange & FORCE_VALID_MASK;
            irqStatus         <= next_irqStatus;
            pinLast           <= pinNow;
            groupLast         <= groupMgmtInterrupt;
            forceLast         <= |forcedMediaChange[1:0];
            reqDone           <= accessReq;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [7:0] rdByte =
        hitEn2     ? smiEnableTwo :
        hitEn3     ? smiEnableThree :
        hitEn4     ? smiEnableFour :
        hitEdge    ? edgePinStatus :
        hitPgs     ? powerGoodSourceSelect :
        hitForce   ? forcedMediaChange :
        hitIrqSts  ? {5'h00, irqStatus} :
        hitIrqMask ? {5'h00, irqMask} : RST_ZERO;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
            response <= 2'b00;
        end else begin
            readdata <= {24'h00_0000, rdByte};
            response <= hitAny ? 2'b00 : 2'b10;  // Unmapped answers slave error.
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    edge_sets_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_09]
        $changed(gpioPin21) |=> edgePinStatus[0])
        else $error("edge on pin 21 not recorded");
    clear_one_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_08]
        (wrTake && hitEdge && wrByte[4] && !pinEdge[2]) |=> !edgePinStatus[4])
        else $error("write one did not clear status");
    reserved_zero_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_10]
        edgePinStatus[7:6] == 2'b00)
        else $error("reserved status bits set");
    pin_route_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_05]
        !mgmtInterruptPinN |-> (groupMgmtInterrupt && smiEnableTwo[7]))
        else $error("pin driven without enable");
    wake_route_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_03]
        groupToWakeLogic == (groupMgmtInterrupt && smiEnableTwo[5]))
        else $error("wake routing wrong");
    serial_route_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_04]
        groupToSerialIrq |-> smiEnableTwo[6])
        else $error("serial routing without enable");
    force_noclear_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_15]
        (forcedMediaChange[0] && !forceClr[0]) |=> forcedMediaChange[0])
        else $error("force bit lost without drive activity");
    force_clear_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_16]
        (floppy.headStepPulse && !(wrTake && hitForce)) |=> forcedMediaChange[1:0] == 2'b00)
        else $error("step did not clear force bits");
    media_flag_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_17]
        (floppy.driveSelectZero && forcedMediaChange[0]) |-> mediaChangedFlag)
        else $error("forced change not shown");
    pg_select_a : assert property (@(posedge clk) disable iff (!resetn) // [RULE_11]
        (secondWatchdogEvent && !powerGoodSourceSelect[0] && !thermalTrip)
            |-> !powerGoodResetRequest)
        else $error("watchdog reached power good while deselected");
    bus_answer_a : assert property (@(posedge clk) disable iff (!resetn)
        (read && waitrequest) |=> !waitrequest)
        else $error("read not answered in one cycle");

endmodule

//--- tb/tb.sv
// Self-checking bench for the management routing register bank.
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import smr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } smr_row_t;
    logic         clk = 1'h0;
    logic         resetn = 1'h0;
    logic [9:0]   address = 10'h000;
    logic         read = 1'h0;
    logic         write = 1'h0;
    logic [31:0]  writedata = 32'h0000_0000;
    logic [3:0]   byteenable = 4'h0;
    logic [31:0]  readdata;
    logic         waitrequest;
    logic [1:0]   response;
    smr_sources_t sources = '0;
    logic [3:0]   pins = 4'h0;
    logic         secondWatchdogEvent = 1'h0;
    logic         thermalTrip = 1'h0;
    smr_floppy_t  floppy = '0;
    logic         groupMgmtInterrupt, mgmtInterruptPinN, groupToSerialIrq, groupToWakeLogic;
    logic         powerGoodResetRequest, secondWatchdogInputBit, mediaChangedFlag, irq;
    logic [7:0]   rdv;
    logic [1:0]   rsp;
    logic [7:0]   bitv;
    int           miscompares = 0;
    int           samplesChecked = 0;
    // Reset values first, then write masks of registers 0x19 to 0x1E.
    smr_row_t     rows [12] = '{
        '{1'h0, 8'h19, 8'h00, 8'h00}, '{1'h0, 8'h1A, 8'h00, 8'h00}, '{1'h0, 8'h1B, 8'h00, 8'h00},
        '{1'h0, 8'h1C, 8'h00, 8'h00}, '{1'h0, 8'h1D, 8'h00, 8'h00}, '{1'h0, 8'h1E, 8'h00, 8'h03},
        '{1'h1, 8'h19, 8'hFF, 8'hF7}, '{1'h1, 8'h1A, 8'hFF, 8'hFE}, '{1'h1, 8'h1B, 8'hFF, 8'hFF},
        '{1'h1, 8'h1C, 8'hFF, 8'h00}, '{1'h1, 8'h1D, 8'hFF, 8'h07}, '{1'h1, 8'h1E, 8'h00, 8'h03}};

    // Half-period toggle gives the 40 MHz clock.
    always #12.5 clk = ~clk;

    smr_routing_regs #(.HAS_EXTRA_UARTS(1'h1)) uut (
        .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .sources(sources),
        .gpioPin21(pins[0]), .gpioPin22(pins[1]), .gpioPin60(pins[2]), .gpioPin61(pins[3]),
        .secondWatchdogEvent(secondWatchdogEvent), .thermalTrip(thermalTrip), .floppy(floppy),
        .groupMgmtInterrupt(groupMgmtInterrupt), .mgmtInterruptPinN(mgmtInterruptPinN),
        .groupToSerialIrq(groupToSerialIrq), .groupToWakeLogic(groupToWakeLogic),
        .powerGoodResetRequest(powerGoodResetRequest),
        .secondWatchdogInputBit(secondWatchdogInputBit),
        .mediaChangedFlag(mediaChangedFlag), .irq(irq));

    // ------------------------------------------------------------------
    // Bus tasks and helpers
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The request is held until the rising edge at which waitrequest is sampled low;
    // the answer is taken at that same edge and only then is the request released.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic [1:0] rs);
        int n;
        @(posedge clk);
        address <= {idx, 2'h0};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h00_0000, wd};
        byteenable <= 4'h1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (waitrequest === 1'h0) break;
        end
        rd = readdata[7:0];
        rs = response;
        if (n == 16) begin
            miscompares++;
            final_report();
        end
        read <= 1'h0;
        write <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'h1, idx, wd, rdv, rsp);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'h0, idx, 8'h00, rdv, rsp);
        `CHK(rdv, exp)
    endtask

    // One source alone active: register r (0 two, 1 three, 2 four), position b.
    function automatic smr_sources_t srcOf(input int r, input int b);
        smr_sources_t s;
        s = '0;
        if (r == 0) begin
            case (b)
                0: s.mouseIrq = 1'h1;
                1: s.keyboardIrq = 1'h1;
                2: s.infraredIrq = 1'h1;
                default: s.mouseClickEvent = 1'h1;
            endcase
        end else if (r == 1) begin
            s.gpioGroupThree[b] = 1'h1;
        end else begin
            s.groupFour[b] = 1'h1;
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
            rdchk(rows[i].idx, rows[i].exp);
        end
        for (int r = 0; r < 5; r++) wr(8'h19 + 8'(r), 8'h00);
        // Each source is blocked until its own enable bit is set.
        for (int r = 0; r < 3; r++) begin
            for (int b = 0; b < 8; b++) begin
                if ((r == 0 && (b == 3 || b > 4)) || (r == 1 && b == 0)) continue;
                @(posedge clk);
                sources <= srcOf(r, b);
                @(negedge clk);
                `CHK(groupMgmtInterrupt, 1'h0)
                wr(8'h19 + 8'(r), 8'h01 << b);
                @(negedge clk);
                `CHK(groupMgmtInterrupt, 1'h1)
                wr(8'h19 + 8'(r), 8'h00);
            end
        end
        // Each route alone, with the mouse source active.
        sources <= srcOf(0, 0);
        for (int b = 5; b < 8; b++) begin
            wr(8'h19, 8'h01 | (8'h01 << b));
            @(negedge clk);
            `CHK({groupToSerialIrq, groupToWakeLogic, ~mgmtInterruptPinN}, 3'(b - 5 == 1 ? 4 : b - 5 == 0 ? 2 : 1))
        end
        sources <= '0;
        wr(8'h19, 8'hE0);
        @(negedge clk);
        `CHK({groupToSerialIrq, groupToWakeLogic, mgmtInterruptPinN}, 3'h1)
        // Power-good sources follow their select bits.
        secondWatchdogEvent <= 1'h1;
        wr(8'h1D, 8'h02);
        @(negedge clk);
        `CHK(powerGoodResetRequest, 1'h0)
        wr(8'h1D, 8'h01);
        @(negedge clk);
        `CHK(powerGoodResetRequest, 1'h1)
        secondWatchdogEvent <= 1'h0;
        thermalTrip <= 1'h1;
        @(negedge clk);
        `CHK(powerGoodResetRequest, 1'h0)
        wr(8'h1D, 8'h06);
        @(negedge clk);
        `CHK({powerGoodResetRequest, secondWatchdogInputBit}, 2'h3)
        // Either pin edge sets its status bit, which only a written one clears.
        wr(8'h30, 8'h07);
        wr(8'h31, 8'h01);
        for (int p = 0; p < 4; p++) begin
            bitv = (p < 2) ? (8'h01 << p) : (8'h10 << (p - 2));
            pins[p] <= 1'h1;
            rdchk(8'h1C, bitv);
            `CHK(irq, 1'h1)
            wr(8'h1C, 8'h00);
            rdchk(8'h1C, bitv);
            wr(8'h1C, bitv);
            rdchk(8'h1C, 8'h00);
            pins[p] <= 1'h0;
            rdchk(8'h1C, bitv);
            wr(8'h1C, bitv);
            wr(8'h30, 8'h07);
            @(negedge clk);
            `CHK(irq, 1'h0)
        end
        pins[0] <= 1'h1;
        wr(8'h31, 8'h00);
        @(negedge clk);
        `CHK(irq, 1'h0)
        // Step clears both force bits; each select clears its own bit.
        floppy.headStepPulse <= 1'h1;
        @(posedge clk);
        floppy.headStepPulse <= 1'h0;
        rdchk(8'h1E, 8'h00);
        wr(8'h1E, 8'h03);
        rdchk(8'h1E, 8'h03);
        floppy.driveSelectZero <= 1'h1;
        @(negedge clk);
        `CHK(mediaChangedFlag, 1'h1)
        @(posedge clk);
        floppy.driveSelectZero <= 1'h0;
        rdchk(8'h1E, 8'h02);
        floppy.driveSelectOne <= 1'h1;
        @(negedge clk);
        `CHK(mediaChangedFlag, 1'h1)
        @(posedge clk);
        floppy.driveSelectOne <= 1'h0;
        rdchk(8'h1E, 8'h00);
        floppy.mediaChangedPin <= 1'h1;
        @(negedge clk);
        `CHK(mediaChangedFlag, 1'h1)
        // An unmapped place answers zero with an error code.
        bus(1'h0, 8'h40, 8'h00, rdv, rsp);
        `CHK({rsp, rdv}, 10'h200)
        // A reset in mid-run restores the defaults.
        wr(8'h19, 8'hFF);
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        rdchk(8'h19, 8'h00);
        rdchk(8'h1E, 8'h03);
        final_report();
    end
endmodule
